// ===== pcp_map.svh
// register offsets, field layouts and reset values of the pin control block
`ifndef PCP_MAP_SVH
`define PCP_MAP_SVH

`define PCP_OFF_DATA       12'h000
`define PCP_OFF_DIR        12'h004
`define PCP_OFF_LATCH      12'h008
`define PCP_OFF_ANALOG     12'h00C
`define PCP_OFF_PULLUP     12'h010
`define PCP_OFF_THRESH     12'h014
`define PCP_OFF_OPTION     12'h018

`define PCP_RST_DIR        8'hFF
`define PCP_RST_ANALOG     8'hFF
`define PCP_RST_PULLUP     8'hFF
`define PCP_RST_THRESH     8'h04
`define PCP_RST_LATCH      8'h00
`define PCP_RST_OPTION     1'b1
`define PCP_RST_SYNC       8'h00
`define PCP_RST_RDATA      32'h0000_0000

`define PCP_ANALOG_IMPL    8'hCF
`define PCP_MASK_FULL      8'hFF
`define PCP_MASK_SMALL     8'h3F
`define PCP_OPT_PULLUP_N   0

`endif

// ===== pcp_pkg.sv
// types shared by the pin control block
package pcp_pkg;

    // per-pin drive controls going out to the pad ring
    typedef struct packed {
        logic [7:0] drive_out;
        logic [7:0] drive_oe;
        logic [7:0] pull_up_on;
        logic [7:0] analog_on;
        logic [7:0] schmitt_sel;
    } pcp_pad_ctl_t;

    // register selected by a bus address
    typedef enum {
        PCP_SEL_DATA,
        PCP_SEL_DIR,
        PCP_SEL_LATCH,
        PCP_SEL_ANALOG,
        PCP_SEL_PULLUP,
        PCP_SEL_THRESH,
        PCP_SEL_OPTION,
        PCP_SEL_NONE
    } pcp_sel_t;

endpackage

// ===== pcp_port_c.sv
// eight-bit bidirectional port pin control with apb register access
// Contract
// - direction bit one tri-states the pin driver; zero makes it an output.
// - writes to the port data register land in the output latch.
// - reads of the port data register return sampled pin levels.
// - output latch holds software-written drive value for every implemented pin.
// - small variant: top two bits of every register unimplemented, read zero.
// - analog select implements bits 7-6 and 3-0; bits 5-4 read zero.
// - pull-up enable bit one enables the pin pull-up, zero disables it.
// - pull-ups act only while global active-low pull-up enable is clear.
// - pull-up is switched off whenever the pin is an output.
// - threshold bit picks schmitt input when one, ttl input when zero.
// - a pin in analog mode reads zero through the port data register.
// - port data writes load the written byte straight into the output latch.
`timescale 1ns/10ps
`include "pcp_map.svh"

module pcp_port_c #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [7:0]            pin_ttl_in,
    input  wire logic [7:0]            pin_schmitt_in,
    input  wire logic [7:0]            periph_own,
    input  wire logic [7:0]            periph_out,
    output pcp_pkg::pcp_pad_ctl_t      pad_ctl
);

    // implemented-bit mask for this variant
    localparam logic [7:0] IMPL =
        SMALL_VARIANT ? `PCP_MASK_SMALL : `PCP_MASK_FULL;

    logic [7:0] dir_q;
    logic [7:0] latch_q;
    logic [7:0] analog_q;
    logic [7:0] pullup_q;
    logic [7:0] thresh_q;
    logic       opt_pullup_n_q;
    logic [7:0] ttl_s1_q;
    logic [7:0] ttl_s2_q;
    logic [7:0] st_s1_q;
    logic [7:0] st_s2_q;
    logic [7:0] pin_level;
    logic [7:0] port_read;
    logic [31:0] rdata_d;
    logic       wr_acc;
    logic       rd_acc;
    pcp_pkg::pcp_sel_t sel;
    logic [7:0] dir_d;
    logic [7:0] latch_d;
    logic [7:0] analog_d;
    logic [7:0] pullup_d;
    logic [7:0] thresh_d;
    logic       opt_pullup_n_d;
    logic [7:0] wr_byte;
    logic       wr_dir;
    logic       wr_latch;
    logic       wr_analog;
    logic       wr_pullup;
    logic       wr_thresh;
    logic       wr_option;

    // address decode, used by both read and write paths
    function automatic pcp_pkg::pcp_sel_t decode(input logic [11:0] a);
        case (a)
            `PCP_OFF_DATA:   decode = pcp_pkg::PCP_SEL_DATA;
            `PCP_OFF_DIR:    decode = pcp_pkg::PCP_SEL_DIR;
            `PCP_OFF_LATCH:  decode = pcp_pkg::PCP_SEL_LATCH;
            `PCP_OFF_ANALOG: decode = pcp_pkg::PCP_SEL_ANALOG;
            `PCP_OFF_PULLUP: decode = pcp_pkg::PCP_SEL_PULLUP;
            `PCP_OFF_THRESH: decode = pcp_pkg::PCP_SEL_THRESH;
            `PCP_OFF_OPTION: decode = pcp_pkg::PCP_SEL_OPTION;
            default:         decode = pcp_pkg::PCP_SEL_NONE;
        endcase
    endfunction

    // apb handshake: zero wait states, error on unmapped address
    assign sel     = decode(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & (sel == pcp_pkg::PCP_SEL_NONE);
    assign wr_acc  = psel & penable & pwrite & pstrb[0]
                     & (sel != pcp_pkg::PCP_SEL_NONE);
    assign rd_acc  = psel & ~penable & ~pwrite;

    // one write strobe per register, all from the shared decode
    assign wr_byte   = pwdata[7:0];
    assign wr_dir    = wr_acc & (sel == pcp_pkg::PCP_SEL_DIR);
    assign wr_analog = wr_acc & (sel == pcp_pkg::PCP_SEL_ANALOG);
    assign wr_pullup = wr_acc & (sel == pcp_pkg::PCP_SEL_PULLUP);
    assign wr_thresh = wr_acc & (sel == pcp_pkg::PCP_SEL_THRESH);
    assign wr_option = wr_acc & (sel == pcp_pkg::PCP_SEL_OPTION);
    // port data writes share the latch with direct latch writes
    assign wr_latch  = wr_acc & ((sel == pcp_pkg::PCP_SEL_LATCH)
                                 | (sel == pcp_pkg::PCP_SEL_DATA));

    // two-stage synchroniser for the ttl buffer of every pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ttl_s1_q <= `PCP_RST_SYNC;
            ttl_s2_q <= `PCP_RST_SYNC;
        end
        else
        begin
            ttl_s1_q <= pin_ttl_in;
            ttl_s2_q <= ttl_s1_q;
        end
    end

    // two-stage synchroniser for the schmitt buffer of every pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_s1_q <= `PCP_RST_SYNC;
            st_s2_q <= `PCP_RST_SYNC;
        end
        else
        begin
            st_s1_q <= pin_schmitt_in;
            st_s2_q <= st_s1_q;
        end
    end

    // per-pin input selection and analog masking
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_pin_in
            assign pin_level[i] = thresh_q[i] ? st_s2_q[i]
                                              : ttl_s2_q[i];
            assign port_read[i] = pin_level[i] & ~analog_q[i]
                                  & IMPL[i];
        end
    endgenerate

    // per-pin pad drive and pull-up control
    generate
        for (genvar i = 0; i < 8; i++)
        begin : g_pin_out
            assign pad_ctl.drive_oe[i]   = ~dir_q[i];
            assign pad_ctl.drive_out[i]  = periph_own[i] ? periph_out[i]
                                                         : latch_q[i];
            assign pad_ctl.pull_up_on[i] = pullup_q[i] & ~opt_pullup_n_q
                                           & dir_q[i];
        end
    endgenerate

    // analog buffer disable and threshold select go to the pads
    assign pad_ctl.analog_on   = analog_q;
    assign pad_ctl.schmitt_sel = thresh_q;

    // next values: masked write data on a strobe, otherwise hold
    always_comb
    begin
        dir_d          = dir_q;
        latch_d        = latch_q;
        analog_d       = analog_q;
        pullup_d       = pullup_q;
        thresh_d       = thresh_q;
        opt_pullup_n_d = opt_pullup_n_q;
        if (wr_dir)
        begin
            dir_d = wr_byte & IMPL;
        end
        if (wr_latch)
        begin
            latch_d = wr_byte & IMPL;
        end
        if (wr_analog)
        begin
            analog_d = wr_byte & `PCP_ANALOG_IMPL & IMPL;
        end
        if (wr_pullup)
        begin
            pullup_d = wr_byte & IMPL;
        end
        if (wr_thresh)
        begin
            thresh_d = wr_byte & IMPL;
        end
        if (wr_option)
        begin
            opt_pullup_n_d = wr_byte[`PCP_OPT_PULLUP_N];
        end
    end

    // direction register, every implemented pin an input after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_q <= `PCP_RST_DIR & IMPL;
        end
        else
        begin
            dir_q <= dir_d;
        end
    end

    // output latch, written directly or through the port data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            latch_q <= `PCP_RST_LATCH;
        end
        else
        begin
            latch_q <= latch_d;
        end
    end

    // analog select, gap bits never stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            analog_q <= `PCP_RST_ANALOG & `PCP_ANALOG_IMPL & IMPL;
        end
        else
        begin
            analog_q <= analog_d;
        end
    end

    // per-pin pull-up enables
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pullup_q <= `PCP_RST_PULLUP & IMPL;
        end
        else
        begin
            pullup_q <= pullup_d;
        end
    end

    // input threshold select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            thresh_q <= `PCP_RST_THRESH;
        end
        else
        begin
            thresh_q <= thresh_d;
        end
    end

    // global active-low pull-up enable, pull-ups off after reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opt_pullup_n_q <= `PCP_RST_OPTION;
        end
        else
        begin
            opt_pullup_n_q <= opt_pullup_n_d;
        end
    end

    // read data mux, sampled in the setup phase
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        case (sel)
            pcp_pkg::PCP_SEL_DATA:   rdata_d[7:0] = port_read;
            pcp_pkg::PCP_SEL_DIR:    rdata_d[7:0] = dir_q;
            pcp_pkg::PCP_SEL_LATCH:  rdata_d[7:0] = latch_q;
            pcp_pkg::PCP_SEL_ANALOG: rdata_d[7:0] = analog_q;
            pcp_pkg::PCP_SEL_PULLUP: rdata_d[7:0] = pullup_q;
            pcp_pkg::PCP_SEL_THRESH: rdata_d[7:0] = thresh_q;
            pcp_pkg::PCP_SEL_OPTION:
                rdata_d[`PCP_OPT_PULLUP_N] = opt_pullup_n_q;
            default:                 rdata_d = 32'h0000_0000;
        endcase
    end

    // registered read data for the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= `PCP_RST_RDATA;
        end
        else if (rd_acc)
        begin
            prdata <= rdata_d;
        end
    end

endmodule

// ===== pcp_port_c_chk.sv
// assertion checker for the port pin control block
`timescale 1ns/10ps
module pcp_port_c_chk #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pslverr,
    input wire logic [7:0]            periph_own,
    input wire pcp_pkg::pcp_pad_ctl_t pad_ctl
);
    // implemented-bit mask of the bound variant
    localparam logic [7:0] IMPL = SMALL_VARIANT ? 8'h3F : 8'hFF;
    logic       wr;
    logic [7:0] d;
    // write strobe at the access edge and its data byte
    assign wr = psel & penable & pwrite & pstrb[0];
    assign d = pwdata[7:0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_dir_drives_oe: assert property (
        wr && paddr == 12'h004 |=> pad_ctl.drive_oe == ~($past(d) & IMPL))
        else $error("oe not from direction");
    a_latch_drives_out: assert property (
        wr && (paddr == 12'h000 || paddr == 12'h008) |=>
        (pad_ctl.drive_out & ~periph_own) == ($past(d) & IMPL & ~periph_own))
        else $error("drive value not from latch");
    a_analog_gap: assert property (pad_ctl.analog_on[5:4] == 2'h0)
        else $error("analog gap bits set");
    a_analog_write: assert property (
        wr && paddr == 12'h00C |=>
        pad_ctl.analog_on == ($past(d) & 8'hCF & IMPL))
        else $error("analog select wrong");
    a_pull_out_off: assert property (
        (pad_ctl.pull_up_on & pad_ctl.drive_oe) == 8'h00)
        else $error("pull-up on output");
    a_pull_global: assert property (
        wr && paddr == 12'h018 && d[0] |=> pad_ctl.pull_up_on == 8'h00)
        else $error("pull-up with global off");
    a_thresh_write: assert property (
        wr && paddr == 12'h014 |=> pad_ctl.schmitt_sel == ($past(d) & IMPL))
        else $error("threshold select wrong");
    a_analog_reads_0: assert property (
        psel && penable && !pwrite && paddr == 12'h000 |->
        (prdata[7:0] & pad_ctl.analog_on) == 8'h00)
        else $error("analog pin read high");
    a_reset_values: assert property ($rose(presetn) |->
        pad_ctl.drive_oe == ~IMPL && pad_ctl.analog_on == (8'hCF & IMPL)
        && pad_ctl.schmitt_sel == 8'h04 && pad_ctl.pull_up_on == 8'h00)
        else $error("reset values wrong");
    // main scenarios reached
    cover property (wr && paddr == 12'h000);
    cover property (pslverr);
    cover property (pad_ctl.pull_up_on != 8'h00);
endmodule
bind pcp_port_c pcp_port_c_chk #(.SMALL_VARIANT(SMALL_VARIANT)) u_chk (.*);

// ===== pcp_pins_model.sv
// external circuitry model on the port pins
`timescale 1ns/10ps
module pcp_pins_model (
    input  wire logic [7:0]            ext_val,
    input  wire logic [7:0]            ext_en,
    input  wire logic [7:0]            near_thr,
    input  wire pcp_pkg::pcp_pad_ctl_t ctl,
    output logic      [7:0]            ttl_lvl,
    output logic      [7:0]            st_lvl
);
    logic [7:0] lvl;
    // pad driver wins, then circuitry, then pull-up or a floating value
    assign lvl = (ctl.drive_oe & ctl.drive_out)
        | (~ctl.drive_oe & ext_en & ext_val)
        | (~ctl.drive_oe & ~ext_en & (ctl.pull_up_on | ~ext_val));
    // near-threshold pins read high via ttl and low via schmitt
    assign ttl_lvl = lvl | near_thr;
    assign st_lvl = lvl & ~near_thr;
endmodule

// ===== test_pcp_port_c.sv
// self-checking testbench of the port pin control block
`timescale 1ns/10ps
module test_pcp_port_c;
    logic                  pclk, presetn, psel, penable, pwrite;
    logic                  pready, pslverr, err_q;
    logic [11:0]           paddr;
    logic [31:0]           pwdata, prdata, rv, prdata_s, rv_s;
    logic [7:0]            ttl, st, own, pout, ext, mid;
    pcp_pkg::pcp_pad_ctl_t pad_ctl;
    int                    errors, cmp_count;
    logic [11:0]           ra [4] = '{12'h004, 12'h00C, 12'h010, 12'h014};
    logic [7:0]            re [4] = '{8'hFF, 8'hCF, 8'hFF, 8'h04};
    pcp_port_c u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_ttl_in(ttl), .pin_schmitt_in(st), .periph_own(own),
        .periph_out(pout), .pad_ctl(pad_ctl));
    // small variant on the same bus and pins, read data only
    pcp_port_c #(.SMALL_VARIANT(1'b1)) u_dut_small (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata_s),
        .pready(), .pslverr(), .pin_ttl_in(ttl), .pin_schmitt_in(st),
        .periph_own(own), .periph_out(pout), .pad_ctl());
    pcp_pins_model u_pins (.ext_val(ext), .ext_en(8'h0F), .near_thr(mid),
        .ctl(pad_ctl), .ttl_lvl(ttl), .st_lvl(st));
    // free-running bus clock
    initial
    begin
        pclk = 1'h0;
        forever #20 pclk = ~pclk;
    end
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, idle cycle first, held until pready
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1)
        begin
            errors++;
            report_and_stop();
        end
        rv = prdata;
        rv_s = prdata_s;
        err_q = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        xfer(1'h0, a, 8'h00);
        chk(rv[7:0], e);
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite} = 4'h0;
        {paddr, pwdata, own, pout, mid} = 68'h0;
        ext = 8'h35;
        errors = 0;
        cmp_count = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        foreach (ra[i])
        begin
            rd(ra[i], re[i]);
            chk(rv_s[7:0], re[i] & 8'h3F);
        end
        xfer(1'h1, 12'h008, 8'hA5);
        rd(12'h008, 8'hA5);
        chk(rv_s[7:0], 8'h25);
        xfer(1'h1, 12'h000, 8'h5A);
        rd(12'h008, 8'h5A);
        $display("test latch done");
        xfer(1'h1, 12'h00C, 8'h00); // analog select off, direction stays input
        xfer(1'h1, 12'h018, 8'h00);
        repeat (3) @(posedge pclk);
        chk(pad_ctl.pull_up_on, 8'hFF);
        rd(12'h000, 8'hF5);
        mid <= 8'h0C;
        repeat (3) @(posedge pclk);
        rd(12'h000, 8'hF9);
        mid <= 8'h00;
        xfer(1'h1, 12'h018, 8'h01);
        repeat (3) @(posedge pclk);
        chk(pad_ctl.pull_up_on, 8'h00);
        rd(12'h000, 8'hC5);
        $display("test inputs done");
        xfer(1'h1, 12'h018, 8'h00);
        xfer(1'h1, 12'h004, 8'h00);
        own <= 8'h01;
        pout <= 8'h01;
        repeat (3) @(posedge pclk);
        chk(pad_ctl.drive_oe, 8'hFF);
        chk(pad_ctl.pull_up_on, 8'h00);
        chk(pad_ctl.drive_out, 8'h5B);
        rd(12'h000, 8'h5B);
        xfer(1'h1, 12'h004, 8'hFF); // analog pins are inputs first
        xfer(1'h1, 12'h00C, 8'hFF);
        rd(12'h00C, 8'hCF);
        repeat (3) @(posedge pclk);
        rd(12'h000, 8'h30);
        chk(rv_s[7:0], 8'h30);
        rd(12'h01C, 8'h00);
        chk({7'h00, err_q}, 8'h01);
        $display("test outputs done");
        report_and_stop();
    end
endmodule
